// file: include/dmic_pkg.sv
// Shared constants for the direct-mapped instruction cache
package dmic_pkg;
    // Geometry: 64 entries of one long word, tag of 24 address bits plus space bit
    localparam int ENTRIES = 64;
    localparam int IDX_W = 6;
    localparam int IDX_LSB = 2;
    localparam int TAG_LSB = 8;
    localparam int TAG_W = 25;
    localparam int WORD_SEL_BIT = 1;
    // Control register selects on the privileged move port
    localparam logic CTL_SEL_CONTROL = 1'h0;
    localparam logic CTL_SEL_FADDR = 1'h1;
    // Field positions of cache_control
    localparam int ON_BIT = 0;
    localparam int HOLD_BIT = 1;
    localparam int WIPE_ONE_BIT = 2;
    localparam int WIPE_ALL_BIT = 3;
    // Reset values
    localparam logic ON_RESET = 1'h0;
    localparam logic HOLD_RESET = 1'h0;
    localparam logic [31:0] FADDR_RESET = 32'h0000_0000;
    // Fetch sequencer, Gray coded along idle-look-bus-reply
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOOK = 2'h1,
        ST_BUS = 2'h3,
        ST_REPLY = 2'h2
    } dmic_state_t;
endpackage

// file: include/dmic_store_if.sv
`timescale 1ns/1ps
// Lookup, fill and invalidate signals between sequencer and entry store
interface dmic_store_if;
    logic [dmic_pkg::IDX_W-1:0] idx; // Entry read and fill index
    logic [dmic_pkg::TAG_W-1:0] rd_tag; // Tag of selected entry
    logic rd_valid; // Valid bit of selected entry
    logic [31:0] rd_data; // Both words of selected entry
    logic wr_en; // Fill strobe
    logic [dmic_pkg::TAG_W-1:0] wr_tag; // Tag to fill
    logic [31:0] wr_data; // Long word to fill
    logic inv_one; // Single-entry invalidate strobe
    logic [dmic_pkg::IDX_W-1:0] inv_idx; // Entry to invalidate
    logic inv_all; // Full invalidate strobe
    modport owner (output idx, wr_en, wr_tag, wr_data, inv_one, inv_idx, inv_all,
                   input rd_tag, rd_valid, rd_data);
    modport store (input idx, wr_en, wr_tag, wr_data, inv_one, inv_idx, inv_all,
                   output rd_tag, rd_valid, rd_data);
endinterface

// file: src/dmic_store.sv
`timescale 1ns/1ps
// Tag, data and valid storage of the cache
module dmic_store #(
    parameter int ENTRIES = dmic_pkg::ENTRIES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    dmic_store_if.store st
);
    // Refuse a depth that the index bits cannot address one to one
    if (ENTRIES != (1 << dmic_pkg::IDX_W)) begin : g_bad_depth
        $error("ENTRIES must match the index width");
    end

    logic [dmic_pkg::TAG_W-1:0] tag_mem [ENTRIES]; // Tags, no reset needed
    logic [31:0] data_mem [ENTRIES]; // Instruction long words
    logic [ENTRIES-1:0] valid_reg; // Valid bits, cleared by reset

    ////////////////////////////////////////////////////////////////////////
    // Combinational read of the indexed entry
    assign st.rd_tag = tag_mem[st.idx];
    assign st.rd_data = data_mem[st.idx];
    assign st.rd_valid = valid_reg[st.idx];

    // Tag and data arrays; plain memory, so no reset
    always_ff @(posedge ref_clk) begin
        if (clk_en && st.wr_en) begin
            tag_mem[st.idx] <= st.wr_tag;
            data_mem[st.idx] <= st.wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One valid flop per entry; a fill wins over a same-cycle invalidate
    // so that a line just fetched is never half lost
    for (genvar i = 0; i < ENTRIES; i++) begin : g_valid
        // Index of this entry, cut to the index width on purpose
        localparam logic [dmic_pkg::IDX_W-1:0] ENTRY_IDX = (dmic_pkg::IDX_W)'(i);
        wire fill_hit = st.wr_en && (st.idx == ENTRY_IDX);
        wire wipe_hit = st.inv_all || (st.inv_one && st.inv_idx == ENTRY_IDX);
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                valid_reg[i] <= 1'h0;
            end else if (clk_en) begin
                if (fill_hit) begin
                    valid_reg[i] <= 1'h1;
                end else if (wipe_hit) begin
                    valid_reg[i] <= 1'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the valid bits
    fill_sets_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && st.wr_en |=> valid_reg[$past(st.idx)])
        else $error("fill did not set valid");
    wipe_all_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && st.inv_all && !st.wr_en |=> valid_reg == '0)
        else $error("full invalidate left a valid entry");
    wipe_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && st.inv_one && !(st.wr_en && st.idx == st.inv_idx)
        |=> !valid_reg[$past(st.inv_idx)])
        else $error("single invalidate missed its entry");
endmodule

// file: src/dmic_cache.sv
`timescale 1ns/1ps
//
// Overview of operation
// - Direct-mapped, 64 entries of one long word
// - Entry holds 25-bit tag, valid, two words
// - Address bits 2-7 pick the entry
// - Hit needs tag match and valid bit
// - Hit returns word picked by bit 1
// - Miss fetches externally, fills unless hold set
// - Fill writes both words of the entry
// - Data accesses never looked up or filled
// - Control register unused bits read zero
// - On bit clear forces misses, no fills
// - Reset clears the on bit
// - Hold keeps hits, blocks overwriting entries
// - Wipe-one clears entry from address register index
// - Wipe-one only on write, reads zero
// - Wipe-all clears every valid bit except one filled that cycle, reads zero
// - Address register used only for wipe-one
// - Registers reachable only by privileged move
// - Inhibit pin synchronised, applied per access
// - Inhibit forces external fetches regardless of on
// - Reset clears valid, on and hold bits
// - Only instruction prefetches are cached
module dmic_cache #(
    parameter int ENTRIES = dmic_pkg::ENTRIES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Fetch port from the processor control unit
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_space,
    input wire logic fetch_instr,
    output logic fetch_ready,
    output logic fetch_done,
    output logic fetch_hit,
    output logic [15:0] fetch_data,
    // External memory access
    output logic ext_req,
    output logic [31:0] ext_addr,
    output logic ext_space,
    input wire logic ext_ack,
    input wire logic [31:0] ext_data,
    // Privileged move port to the two control registers
    input wire logic ctl_priv,
    input wire logic ctl_sel,
    input wire logic ctl_wr,
    input wire logic ctl_rd,
    input wire logic [31:0] ctl_wdata,
    output logic [31:0] ctl_rdata,
    // Cache disable pin, active low, asynchronous
    input wire logic ext_inhibit_pin_n
);
    // Index, tag and store widths are fixed to this depth
    if (ENTRIES != dmic_pkg::ENTRIES) begin : g_bad_entries
        $error("only 64 entries are supported");
    end

    dmic_store_if st (); // Carrier to the entry store

    // Entry storage, 64 direct-mapped entries
    dmic_store #(
        .ENTRIES(ENTRIES)
    ) u_store (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .st(st.store)
    );

    ////////////////////////////////////////////////////////////////////////
    // Inhibit pin synchroniser: three stages, change taken when 1 and 2 agree
    // Pin is unrelated to ref_clk, so stage 0 may go metastable;
    // agreement of the last two stages also drops a one-cycle glitch.
    // Pin to filtered level takes four to five edges.
    logic [2:0] inh_sync_reg; // Stage 0 is read only by stage 1
    logic inh_reg; // Filtered, active-high inhibit level
    wire inh_agree = (inh_sync_reg[1] == inh_sync_reg[2]);

    // Pin is active low, so the sampled level is inverted at the input
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inh_sync_reg <= 3'h0;
            inh_reg <= 1'h0;
        end else if (clk_en) begin
            inh_sync_reg <= {inh_sync_reg[1:0], ~ext_inhibit_pin_n};
            if (inh_agree) begin
                inh_reg <= inh_sync_reg[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    // A write lands at the edge that takes it; read data follows one
    // cycle later and stands for that cycle only.
    // Wipe bits are strobes, not storage, hence they read as zero.
    logic on_reg; // Cache enable
    logic hold_reg; // Freeze: serve hits, no fills
    logic [31:0] faddr_reg; // Cache function address
    logic [31:0] ctl_rdata_reg; // Read data, one cycle after the read strobe

    // Only a privileged move reaches the registers
    wire ctl_wr_ok = ctl_wr && ctl_priv;
    wire ctl_rd_ok = ctl_rd && ctl_priv;
    wire ctrl_wr = ctl_wr_ok && (ctl_sel == dmic_pkg::CTL_SEL_CONTROL);
    // Address register write has no effect beyond storing the word
    wire faddr_wr = ctl_wr_ok && (ctl_sel == dmic_pkg::CTL_SEL_FADDR);
    // Wipe bits act only as a side effect of this write and are never stored
    wire wipe_all = ctrl_wr && ctl_wdata[dmic_pkg::WIPE_ALL_BIT];
    wire wipe_one = ctrl_wr && ctl_wdata[dmic_pkg::WIPE_ONE_BIT] && !wipe_all;
    // Read view: only on and hold exist, all else reads zero
    wire [31:0] ctrl_view = {30'h0, hold_reg, on_reg};
    wire [31:0] rd_sel = (ctl_sel == dmic_pkg::CTL_SEL_CONTROL) ? ctrl_view : faddr_reg;

    // Register writes and read capture
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            on_reg <= dmic_pkg::ON_RESET;
            hold_reg <= dmic_pkg::HOLD_RESET;
            faddr_reg <= dmic_pkg::FADDR_RESET;
            ctl_rdata_reg <= 32'h0;
        end else if (clk_en) begin
            if (ctrl_wr) begin
                on_reg <= ctl_wdata[dmic_pkg::ON_BIT];
                hold_reg <= ctl_wdata[dmic_pkg::HOLD_BIT];
            end
            if (faddr_wr) begin
                faddr_reg <= ctl_wdata;
            end
            // Unprivileged reads return zero rather than leak state
            ctl_rdata_reg <= ctl_rd_ok ? rd_sel : 32'h0;
        end
    end

    // Invalidates take the index from the address register, tag ignored
    assign st.inv_all = clk_en && wipe_all;
    assign st.inv_one = clk_en && wipe_one;
    assign st.inv_idx = faddr_reg[dmic_pkg::IDX_LSB +: dmic_pkg::IDX_W];
    assign ctl_rdata = ctl_rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Fetch sequencer
    // IDLE takes a request, LOOK reads the entry, BUS waits for
    // memory on a miss or bypass, REPLY shows the word one cycle.
    // A hit costs two cycles, a miss three plus the wait states.
    // One fetch outstanding; the next is taken back in IDLE.
    dmic_pkg::dmic_state_t state_reg, state_next;
    logic [31:0] addr_reg; // Accepted fetch address
    logic space_reg; // Accepted space tag bit
    logic instr_reg; // Accepted access is an instruction prefetch
    logic active_reg; // Cache usable for this access
    logic hit_reg; // Last reply came from the cache
    logic [15:0] data_reg; // Reply word

    wire accept = fetch_req && (state_reg == dmic_pkg::ST_IDLE);
    // Enable and inhibit are judged once per access, at its acceptance,
    // so a pin change never splits a lookup from its fill
    wire active_now = on_reg && !inh_reg;
    wire [dmic_pkg::TAG_W-1:0] req_tag = {addr_reg[31:dmic_pkg::TAG_LSB], space_reg};
    // Lookup only for enabled instruction fetches
    wire lookup = active_reg && instr_reg;
    wire tag_match = (st.rd_tag == req_tag) && st.rd_valid;
    wire hit = lookup && tag_match;
    // Bit 1 clear picks the upper half: the long word is big-endian
    wire [15:0] hit_word = addr_reg[dmic_pkg::WORD_SEL_BIT] ? st.rd_data[15:0]
                                                            : st.rd_data[31:16];
    wire [15:0] ext_word = addr_reg[dmic_pkg::WORD_SEL_BIT] ? ext_data[15:0]
                                                            : ext_data[31:16];
    // Fill only for enabled, unfrozen instruction misses
    wire fill_ok = lookup && !hold_reg;
    wire bus_end = (state_reg == dmic_pkg::ST_BUS) && ext_ack;

    // Next-state selection
    // All four codes are used, so no default item is needed
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            dmic_pkg::ST_IDLE: begin
                if (fetch_req) begin
                    state_next = dmic_pkg::ST_LOOK;
                end
            end
            dmic_pkg::ST_LOOK: begin
                // Miss or bypass goes to the bus
                state_next = hit ? dmic_pkg::ST_REPLY : dmic_pkg::ST_BUS;
            end
            dmic_pkg::ST_BUS: begin
                if (ext_ack) begin
                    state_next = dmic_pkg::ST_REPLY;
                end
            end
            dmic_pkg::ST_REPLY: begin
                state_next = dmic_pkg::ST_IDLE;
            end
        endcase
    end

    // State and captured request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= dmic_pkg::ST_IDLE;
            addr_reg <= 32'h0;
            space_reg <= 1'h0;
            instr_reg <= 1'h0;
            active_reg <= 1'h0;
        end else if (clk_en) begin
            state_reg <= state_next;
            if (accept) begin
                addr_reg <= fetch_addr;
                space_reg <= fetch_space;
                instr_reg <= fetch_instr;
                active_reg <= active_now;
            end
        end
    end

    // Reply word and its source
    // Held until the next reply, so a slow consumer may read it late
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_reg <= 16'h0;
            hit_reg <= 1'h0;
        end else if (clk_en) begin
            if (state_reg == dmic_pkg::ST_LOOK && hit) begin
                data_reg <= hit_word;
                hit_reg <= 1'h1;
            end else if (bus_end) begin
                data_reg <= ext_word;
                hit_reg <= 1'h0;
            end
        end
    end

    // Store lookup and fill; the index comes straight from bits 2-7
    // The captured address keeps the entry read in LOOK and the
    // entry filled at the end of BUS the same one
    assign st.idx = addr_reg[dmic_pkg::IDX_LSB +: dmic_pkg::IDX_W];
    assign st.wr_en = clk_en && bus_end && fill_ok;
    assign st.wr_tag = req_tag;
    assign st.wr_data = ext_data;

    // External access is always an aligned long word
    // Request stands from entering BUS up to the ack edge; the
    // returned word is taken only at that edge
    assign ext_req = (state_reg == dmic_pkg::ST_BUS);
    assign ext_addr = {addr_reg[31:2], 2'h0};
    assign ext_space = space_reg;
    assign fetch_ready = (state_reg == dmic_pkg::ST_IDLE);
    assign fetch_done = (state_reg == dmic_pkg::ST_REPLY);
    assign fetch_hit = hit_reg;
    assign fetch_data = data_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Gated by reset; a frozen clock enable leaves them idle
    hit_reply_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == dmic_pkg::ST_LOOK && hit
        |=> fetch_done && fetch_hit && fetch_data == $past(hit_word) && !ext_req)
        else $error("hit did not reply from the cache");
    miss_bus_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == dmic_pkg::ST_LOOK && !tag_match |=> ext_req)
        else $error("miss did not go external");
    off_bypass_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == dmic_pkg::ST_LOOK && !active_reg |-> !hit ##1 ext_req)
        else $error("disabled cache served a hit");
    data_nofill_a: assert property (@(posedge ref_clk) disable iff (rst)
        st.wr_en |-> instr_reg && active_reg)
        else $error("non-instruction or bypassed access filled");
    hold_nofill_a: assert property (@(posedge ref_clk) disable iff (rst)
        st.wr_en |-> !hold_reg)
        else $error("fill while hold set");
    ctrl_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && ctl_rd_ok && ctl_sel == dmic_pkg::CTL_SEL_CONTROL
        |=> ctl_rdata[31:2] == 30'h0)
        else $error("control register unused bits not zero");
    inhibit_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && accept && inh_reg |=> !active_reg && !hit)
        else $error("inhibit did not bypass the cache");
    ext_done_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && bus_end |=> fetch_done && !fetch_hit && fetch_data == $past(ext_word))
        else $error("external fetch reply wrong");

    // Further checks on the fetch and register ports
    data_bus_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == dmic_pkg::ST_LOOK && !instr_reg |-> !hit ##1 ext_req)
        else $error("data access looked up in the cache");
    hold_hit_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == dmic_pkg::ST_LOOK && hold_reg && lookup && tag_match
        |=> fetch_done && fetch_hit)
        else $error("frozen cache stopped serving hits");
    unpriv_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && ctl_rd && !ctl_priv |=> ctl_rdata == 32'h0)
        else $error("unprivileged read returned register state");
    // Runs outside the reset gate: it looks at the release itself
    reset_clear_a: assert property (@(posedge ref_clk)
        $fell(rst) |-> !on_reg && !hold_reg && fetch_ready && !fetch_done)
        else $error("reset left the cache enabled or busy");
endmodule

// file: dv/dmic_mem_model.sv
`timescale 1ns/1ps
// External memory on the miss port: word is the aligned address mixed with a salt
module dmic_mem_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ext_req,
    input wire logic [31:0] ext_addr,
    input wire logic ext_space,
    input wire logic slow,
    input wire logic [31:0] salt,
    output logic ext_ack,
    output logic [31:0] ext_data
);
    logic [2:0] wait_reg; // Wait states spent on this request
    logic [31:0] word_reg; // Word of the current reply
    logic [2:0] lat_w; // Wait states wanted
    assign lat_w = slow ? 3'h4 : 3'h0;
    // Idle bus shows the inverted last word, so a stale value never passes for a reply
    assign ext_data = ext_ack ? word_reg : ~word_reg;
    ////////////////////////////////////////////////////////////////////////
    // Single-cycle acknowledge after zero or four wait states
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ext_ack <= 1'b0;
            wait_reg <= 3'h0;
            word_reg <= 32'h0;
        end else if (ext_ack) begin
            // Reply taken, request drops next cycle
            ext_ack <= 1'b0;
            wait_reg <= 3'h0;
        end else if (ext_req) begin
            wait_reg <= wait_reg + 3'h1;
            if (wait_reg >= lat_w) begin
                ext_ack <= 1'b1;
                // Space bit rides in bit 1, so a wrong space shows in the data
                word_reg <= {ext_addr[31:2], ext_space, 1'b0} ^ salt;
            end
        end
    end
endmodule

// file: dv/tb_direct_mapped_instruction_cache.sv
`timescale 1ns/1ps
// Self-checking bench for the instruction cache
module tb_direct_mapped_instruction_cache;
    logic ref_clk, rst, clk_en, inhibit_n; // Clock, reset, enable, cache disable pin
    logic fetch_req, fetch_space, fetch_instr, fetch_ready, fetch_done, fetch_hit;
    logic [31:0] fetch_addr; // Fetch byte address
    logic [15:0] fetch_data; // Returned word
    logic ext_req, ext_space, ext_ack, mem_slow; // Miss port and memory pace
    logic [31:0] ext_addr, ext_data, mem_salt; // Miss port and memory contents
    logic ctl_priv, ctl_sel, ctl_wr, ctl_rd; // Privileged move port
    logic [31:0] ctl_wdata, ctl_rdata;
    int failures, num_checks, cycles; // Score and watchdog
    localparam logic [31:0] A = 32'h0000_1234; // Index 0x0d
    localparam logic [31:0] B = 32'h0000_5678; // Index 0x1e
    localparam logic [31:0] C = 32'h0000_9a40; // Index 0x10
    dmic_cache i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_space(fetch_space),
        .fetch_instr(fetch_instr), .fetch_ready(fetch_ready), .fetch_done(fetch_done),
        .fetch_hit(fetch_hit), .fetch_data(fetch_data), .ext_req(ext_req),
        .ext_addr(ext_addr), .ext_space(ext_space), .ext_ack(ext_ack), .ext_data(ext_data),
        .ctl_priv(ctl_priv), .ctl_sel(ctl_sel), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
        .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .ext_inhibit_pin_n(inhibit_n));
    dmic_mem_model i_mem (.ref_clk(ref_clk), .rst(rst), .ext_req(ext_req),
        .ext_addr(ext_addr), .ext_space(ext_space), .slow(mem_slow), .salt(mem_salt),
        .ext_ack(ext_ack), .ext_data(ext_data));
    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Word picked by bit 1 out of the salted long word
    function automatic logic [15:0] half(input logic [31:0] a, input logic sp,
                                         input logic [31:0] s);
        logic [31:0] w;
        w = {a[31:2], sp, 1'b0} ^ s;
        return a[1] ? w[15:0] : w[31:16];
    endfunction
    // One fetch, held until taken; salt names the memory state the word came from
    task automatic fetch(input logic [31:0] a, input logic sp, input logic ins,
                         input logic exp_hit, input logic [31:0] s);
        int n;
        fetch_addr = a;
        fetch_space = sp;
        fetch_instr = ins;
        fetch_req = 1'b1;
        n = 0;
        while (fetch_ready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        #1;
        fetch_req = 1'b0;
        n = 0;
        // Bounded wait, slow memory needs well under fifty cycles
        while (fetch_done !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("fetch hit", {31'h0, fetch_hit}, {31'h0, exp_hit});
        check("fetch data", {16'h0, fetch_data}, {16'h0, half(a, sp, s)});
    endtask
    task automatic ctl_write(input logic priv, input logic sel, input logic [31:0] d);
        ctl_priv = priv;
        ctl_sel = sel;
        ctl_wdata = d;
        ctl_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        ctl_wr = 1'b0;
        ctl_priv = 1'b1;
        // Idle edge, so a following call never re-raises a strobe in this step
        @(posedge ref_clk);
        #1;
    endtask
    // Read data stands only in the cycle after the taking edge
    task automatic ctl_read(input logic priv, input logic sel, input logic [31:0] exp);
        ctl_priv = priv;
        ctl_sel = sel;
        ctl_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        ctl_rd = 1'b0;
        ctl_priv = 1'b1;
        check("register read", ctl_rdata, exp);
        @(posedge ref_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        ctl_read(1'b1, 1'b0, 32'h0);
        ctl_read(1'b1, 1'b1, 32'h0);
        fetch(A, 1'b0, 1'b1, 1'b0, mem_salt);
        fetch(A, 1'b0, 1'b1, 1'b0, mem_salt);
    endtask
    task automatic t_fill_hit();
        ctl_write(1'b1, 1'b0, 32'hffff_fff1);
        ctl_read(1'b1, 1'b0, 32'h1);
        fetch(A, 1'b0, 1'b1, 1'b0, 32'h0);
        mem_salt = 32'h5a5a_a5a5;
        fetch(A, 1'b0, 1'b1, 1'b1, 32'h0);
        fetch(A | 32'h2, 1'b0, 1'b1, 1'b1, 32'h0);
        fetch(A, 1'b1, 1'b1, 1'b0, mem_salt);
        fetch(A ^ 32'h100, 1'b0, 1'b1, 1'b0, mem_salt);
        fetch(A, 1'b0, 1'b1, 1'b0, mem_salt);
    endtask
    task automatic t_data();
        mem_slow = 1'b1;
        fetch(B, 1'b0, 1'b0, 1'b0, mem_salt);
        fetch(B, 1'b0, 1'b0, 1'b0, mem_salt);
        fetch(B, 1'b0, 1'b1, 1'b0, mem_salt);
        fetch(B | 32'h2, 1'b0, 1'b1, 1'b1, mem_salt);
        mem_slow = 1'b0;
    endtask
    task automatic t_hold();
        ctl_write(1'b1, 1'b0, 32'h3);
        ctl_read(1'b1, 1'b0, 32'h3);
        fetch(B, 1'b0, 1'b1, 1'b1, mem_salt);
        fetch(C, 1'b0, 1'b1, 1'b0, mem_salt);
        fetch(C, 1'b0, 1'b1, 1'b0, mem_salt);
        ctl_write(1'b1, 1'b0, 32'h1);
    endtask
    task automatic t_wipe();
        fetch(A, 1'b0, 1'b1, 1'b1, mem_salt);
        ctl_write(1'b1, 1'b1, 32'hffff_ff37);
        ctl_read(1'b1, 1'b1, 32'hffff_ff37);
        ctl_write(1'b0, 1'b0, 32'h0);
        ctl_read(1'b1, 1'b0, 32'h1);
        ctl_read(1'b0, 1'b0, 32'h0);
        ctl_write(1'b1, 1'b0, 32'h5);
        ctl_read(1'b1, 1'b0, 32'h1);
        fetch(A, 1'b0, 1'b1, 1'b0, mem_salt);
        fetch(B, 1'b0, 1'b1, 1'b1, mem_salt);
        ctl_write(1'b1, 1'b0, 32'h9);
        ctl_read(1'b1, 1'b0, 32'h1);
        fetch(B, 1'b0, 1'b1, 1'b0, mem_salt);
        fetch(A, 1'b0, 1'b1, 1'b0, mem_salt);
        ctl_write(1'b1, 1'b0, 32'hd);
        fetch(A, 1'b0, 1'b1, 1'b0, mem_salt);
        fetch(B, 1'b0, 1'b1, 1'b0, mem_salt);
    endtask
    // Pin goes through a synchroniser, so give it eight cycles each way
    task automatic t_inhibit();
        fetch(A, 1'b0, 1'b1, 1'b1, mem_salt);
        inhibit_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        fetch(A, 1'b0, 1'b1, 1'b0, mem_salt);
        // Wipe-one while the pin disables the cache still acts
        ctl_write(1'b1, 1'b0, 32'h5);
        inhibit_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        fetch(A, 1'b0, 1'b1, 1'b0, mem_salt);
        fetch(A, 1'b0, 1'b1, 1'b1, mem_salt);
        // Frozen clock enable: a wipe-all write must leave no trace
        clk_en = 1'b0;
        ctl_write(1'b1, 1'b0, 32'h9);
        clk_en = 1'b1;
        fetch(A, 1'b0, 1'b1, 1'b1, mem_salt);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic conclude();
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // 5 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Watchdog, the whole sequence needs well under a thousand cycles
    initial begin
        cycles = 0;
        forever begin
            @(posedge ref_clk);
            cycles++;
            if (cycles == 5000) begin
                failures++;
                conclude();
            end
        end
    end
    // Main sequence
    initial begin
        {rst, clk_en, inhibit_n, ctl_priv} = 4'hf;
        {fetch_req, fetch_space, fetch_instr, mem_slow, ctl_sel, ctl_wr, ctl_rd} = 7'h0;
        {fetch_addr, mem_salt, ctl_wdata} = 96'h0;
        failures = 0;
        num_checks = 0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_fill_hit();
        t_data();
        t_hold();
        t_wipe();
        t_inhibit();
        conclude();
    end
endmodule
